// >>> common/selchk_consts.svh
// Purpose: Offsets, field positions, codes and reset values of the selector checker
// Assumes: 8-bit byte address, 32-bit data, one word per register
// Notes:   Field macros expand to part-select ranges
`ifndef SELCHK_CONSTS_SVH
`define SELCHK_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_PSEL  8'h00
`define OFF_MSEL  8'h04
`define OFF_FID   8'h08
`define OFF_ESR   8'h0C
`define OFF_PCFG  8'h10
`define OFF_MCFG  8'h14
`define OFF_CTRL  8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_SEL   15:0
`define F_CODE  19:16
`define F_RIS   27:24
`define B_OVR   31

// ----------------------------------------
// Error codes
// ----------------------------------------
`define ERR_NONE   4'h0
`define ERR_PARTITION_IDENTIFIER 4'h1
`define ERR_MONSEL 4'h5
`define ERR_RIS    4'h8

// ----------------------------------------
// Control bits and reset values
// ----------------------------------------
`define CTL_CHK_PID 0
`define CTL_CHK_RIS 1
`define CTL_CHK_MON 2
`define CTL_ZERO_RD 3
`define CTRL_RST    4'hF
`define WORD_ZERO   32'h0000_0000

`endif

// >>> common/selchk_pkg.sv
// Purpose: Types shared by the selector checker files
// Assumes: Constants come from selchk_consts.svh
// Notes:   Types only; numbers live in the header
package selchk_pkg;
    typedef logic [3:0]  err_code_t;   // Error code field
    typedef logic [31:0] word_t;       // Register word
endpackage : selchk_pkg

// >>> rtl/range_checker.sv
// Purpose: Compare one selector value against its implemented count
// Assumes: Valid values are 0 .. count-1
// Notes:   Pure combinational, one instance per selector check
`timescale 1ns/10ps
module range_checker #(
    parameter int W = 16                 // Selector width
) (
    input  wire logic [W-1:0] value,        // Selector under test
    input  wire logic [W-1:0] count,        // Number of valid values
    output logic              out_of_range  // High when value not implemented
);
    // Count of zero makes every value illegal, which is the safe answer
    assign out_of_range = (value >= count);
endmodule : range_checker

// >>> rtl/selector_range_error_check.sv
// Purpose: Selector registers, range checks and error status recording
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Check-at-write options are software controls, reset to enabled
`timescale 1ns/10ps
`include "selchk_consts.svh"
module selector_range_error_check
    import selchk_pkg::*;
#(
    parameter int              PART_COUNT = 16,   // Implemented partitions, power of two
    parameter int              RIS_COUNT  = 3,    // Implemented resource instances, 1..4
    parameter int              MON_DEPTH  = 8,    // Monitor storage per instance
    parameter logic [63:0]     MON_LIMITS = 64'h0008_0008_0004_0004, // Monitors per instance
    parameter logic [31:0]     FEATURE_ID = 32'h0000_0A5A  // Arbitrary identification value
) (
    input  wire logic        sys_clk,           // System clock, 25 MHz
    input  wire logic        reset_n,           // Synchronous reset, active low
    input  wire logic [7:0]  reg_addr,          // Byte address
    input  wire logic [31:0] reg_wdata,         // Write data
    input  wire logic        reg_wr,            // Write strobe
    input  wire logic        reg_rd,            // Read strobe
    input  wire logic        secure_space_bit,  // 1 = non-secure access
    output logic      [31:0] reg_rdata          // Read data, cycle after strobe
);
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int PW = $clog2(PART_COUNT);     // Partition index bits
    localparam int MW = $clog2(MON_DEPTH);      // Monitor index bits
    localparam logic [15:0] PCNT = 16'(PART_COUNT);
    localparam logic [3:0]  RCNT = 4'(RIS_COUNT);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0] pid_ff;              // Partition id selector
    logic [3:0]  pris_ff;             // Resource instance selector
    logic [15:0] mon_ff;              // Monitor instance selector
    logic [3:0]  mris_ff;             // Monitor resource instance selector
    logic [3:0]  ctrl_ff;             // Check and read-zero options
    word_t       esr_ff [2];          // Error status, [0] secure, [1] non-secure
    word_t       rdata_ff;            // Registered read data
    word_t       pcfg_mem [4*PART_COUNT]; // Partition configuration words
    word_t       mcfg_mem [4*MON_DEPTH];  // Monitor configuration words

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire ps_wr = reg_wr & (reg_addr == `OFF_PSEL);
    wire ms_wr = reg_wr & (reg_addr == `OFF_MSEL);
    wire es_wr = reg_wr & (reg_addr == `OFF_ESR);
    wire ct_wr = reg_wr & (reg_addr == `OFF_CTRL);
    wire pc_wr = reg_wr & (reg_addr == `OFF_PCFG);
    wire mc_wr = reg_wr & (reg_addr == `OFF_MCFG);
    wire pc_rd = reg_rd & (reg_addr == `OFF_PCFG);
    wire mc_rd = reg_rd & (reg_addr == `OFF_MCFG);
    wire fi_rd = reg_rd & (reg_addr == `OFF_FID);
    wire pc_acc = pc_rd | pc_wr;      // Any partition config access
    wire mc_acc = mc_rd | mc_wr;      // Any monitor config access

    // Incoming fields of a written selector word
    wire [15:0] w_sel = reg_wdata[`F_SEL];
    wire [3:0]  w_ris = reg_wdata[`F_RIS];

    // Per-instance monitor bounds; all types in an instance share one count
    wire [1:0]  nlim_ix = w_ris[1:0];
    wire [1:0]  clim_ix = mris_ff[1:0];
    wire [15:0] mon_lim_new = MON_LIMITS[nlim_ix*16 +: 16];
    wire [15:0] mon_lim_cur = MON_LIMITS[clim_ix*16 +: 16];

    // ----------------------------------------
    // Range checks
    // ----------------------------------------
    logic new_pid_bad, cur_pid_bad, new_ris_bad, cur_ris_bad;
    logic new_mris_bad, cur_mris_bad, new_mon_bad, cur_mon_bad;

    range_checker #(.W(16)) u_pid_new (.value(w_sel), .count(PCNT), .out_of_range(new_pid_bad));
    range_checker #(.W(16)) u_pid_cur (.value(pid_ff), .count(PCNT), .out_of_range(cur_pid_bad));
    range_checker #(.W(4))  u_ris_new (.value(w_ris), .count(RCNT), .out_of_range(new_ris_bad));
    range_checker #(.W(4))  u_ris_cur (.value(pris_ff), .count(RCNT), .out_of_range(cur_ris_bad));
    range_checker #(.W(4))  u_mrs_new (.value(w_ris), .count(RCNT), .out_of_range(new_mris_bad));
    range_checker #(.W(4))  u_mrs_cur (.value(mris_ff), .count(RCNT),
                                       .out_of_range(cur_mris_bad));
    range_checker #(.W(16)) u_mon_new (.value(w_sel), .count(mon_lim_new),
                                       .out_of_range(new_mon_bad));
    range_checker #(.W(16)) u_mon_cur (.value(mon_ff), .count(mon_lim_cur),
                                       .out_of_range(cur_mon_bad));

    // ----------------------------------------
    // Error classification
    // ----------------------------------------
    // Write-time checks on the selector registers
    wire rej_pid = ps_wr & ctrl_ff[`CTL_CHK_PID] & new_pid_bad;
    wire rej_ris = ps_wr & ctrl_ff[`CTL_CHK_RIS] & new_ris_bad;
    wire ps_rej  = rej_pid | rej_ris;
    // Bound is known only once the written instance is defined
    wire ms_rej  = ms_wr & ctrl_ff[`CTL_CHK_MON] & ~new_mris_bad & new_mon_bad;
    // Use-time checks; partition range has priority over instance
    wire use_e1  = pc_acc & cur_pid_bad;
    wire use_e8  = ((pc_acc & ~cur_pid_bad) | fi_rd) & cur_ris_bad;
    // Monitor range only judged while its instance is defined
    wire use_e5  = mc_acc & ~cur_mris_bad & cur_mon_bad;
    wire pc_err  = use_e1 | use_e8;

    wire        err_vld = ps_rej | ms_rej | use_e1 | use_e8 | use_e5;
    err_code_t  err_code;             // Code to record
    logic [3:0] err_ris;              // Captured instance selector
    logic [15:0] err_sel;             // Captured partition or monitor selector

    // Captured syndrome: written values on rejects, stored values on use
    always_comb begin
        err_code = `ERR_NONE;
        err_ris  = pris_ff;
        err_sel  = pid_ff;
        if (rej_pid) begin
            err_code = `ERR_PARTITION_IDENTIFIER;
            err_ris  = w_ris;
            err_sel  = w_sel;
        end else if (rej_ris) begin
            // Instance and partition selectors go with the code
            err_code = `ERR_RIS;
            err_ris  = w_ris;
            err_sel  = w_sel;
        end else if (ms_rej) begin
            err_code = `ERR_MONSEL;
            err_ris  = w_ris;
            err_sel  = w_sel;
        end else if (use_e1) begin
            err_code = `ERR_PARTITION_IDENTIFIER;
        end else if (use_e8) begin
            err_code = `ERR_RIS;
        end else if (use_e5) begin
            err_code = `ERR_MONSEL;
            err_ris  = mris_ff;
            err_sel  = mon_ff;
        end
    end

    // ----------------------------------------
    // Error status update
    // ----------------------------------------
    word_t nxt_esr [2];               // Next value of each copy

    // Hardware recording wins over a software write in the same cycle
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            nxt_esr[c] = esr_ff[c];
            if (err_vld && (secure_space_bit == c[0])) begin
                nxt_esr[c]           = `WORD_ZERO;
                nxt_esr[c][`F_SEL]   = err_sel;
                nxt_esr[c][`F_CODE]  = err_code;
                nxt_esr[c][`F_RIS]   = err_ris;
                // Sticky flag, set when a recorded code is overwritten
                nxt_esr[c][`B_OVR]   = esr_ff[c][`B_OVR] | (esr_ff[c][`F_CODE] != `ERR_NONE);
            end else if (es_wr && (secure_space_bit == c[0])) begin
                nxt_esr[c]           = `WORD_ZERO;
                nxt_esr[c][`F_SEL]   = reg_wdata[`F_SEL];
                nxt_esr[c][`F_CODE]  = reg_wdata[`F_CODE];
                nxt_esr[c][`F_RIS]   = reg_wdata[`F_RIS];
                nxt_esr[c][`B_OVR]   = reg_wdata[`B_OVR];
            end
        end
    end

    // ----------------------------------------
    // Storage indices and read mux
    // ----------------------------------------
    wire [PW+1:0] p_ix = {pris_ff[1:0], pid_ff[PW-1:0]};
    wire [MW+1:0] m_ix = {mris_ff[1:0], mon_ff[MW-1:0]};
    wire          ns_ix = secure_space_bit;

    word_t nxt_rdata;                 // Read value chosen this cycle

    always_comb begin
        nxt_rdata = `WORD_ZERO;
        unique case (reg_addr)
            `OFF_PSEL: begin
                nxt_rdata[`F_SEL] = pid_ff;
                nxt_rdata[`F_RIS] = pris_ff;
            end
            `OFF_MSEL: begin
                nxt_rdata[`F_SEL] = mon_ff;
                nxt_rdata[`F_RIS] = mris_ff;
            end
            // A bad instance still returns the identification word: any value is legal
            `OFF_FID:  nxt_rdata = FEATURE_ID;
            `OFF_ESR:  nxt_rdata = esr_ff[ns_ix];
            `OFF_CTRL: nxt_rdata[3:0] = ctrl_ff;
            // Erroneous reads give zero or the truncated index's word
            `OFF_PCFG: nxt_rdata = (pc_err & ctrl_ff[`CTL_ZERO_RD]) ? `WORD_ZERO : pcfg_mem[p_ix];
            `OFF_MCFG: nxt_rdata = (use_e5 & ctrl_ff[`CTL_ZERO_RD]) ? `WORD_ZERO : mcfg_mem[m_ix];
            default:   nxt_rdata = `WORD_ZERO;  // Unmapped reads as zero
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!reset_n) rdata_ff <= `WORD_ZERO;
        else          rdata_ff <= reg_rd ? nxt_rdata : `WORD_ZERO;
    end
    assign reg_rdata = rdata_ff;

    // ----------------------------------------
    // Selector and control registers
    // ----------------------------------------
    // A rejected write leaves the whole selector word unchanged
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pid_ff  <= 16'h0000;
            pris_ff <= 4'h0;
            mon_ff  <= 16'h0000;
            mris_ff <= 4'h0;
            ctrl_ff <= `CTRL_RST;
        end else begin
            if (ps_wr && !ps_rej) begin
                pid_ff  <= w_sel;
                pris_ff <= w_ris;
            end
            if (ms_wr && !ms_rej) begin
                mon_ff  <= w_sel;
                mris_ff <= w_ris;
            end
            if (ct_wr) ctrl_ff <= reg_wdata[3:0];
        end
    end

    // Error status copies
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            esr_ff[0] <= `WORD_ZERO;
            esr_ff[1] <= `WORD_ZERO;
        end else begin
            esr_ff[0] <= nxt_esr[0];
            esr_ff[1] <= nxt_esr[1];
        end
    end

    // ----------------------------------------
    // Configuration storage
    // ----------------------------------------
    // Writes with a recorded selector error are dropped rather than aliased
    wire pc_we = pc_wr & ~pc_err;
    wire mc_we = mc_wr & ~use_e5;
    // Only the three errors are detected here, so an undefined monitor instance still writes its truncated index's word
    always_ff @(posedge sys_clk) begin
        if (pc_we) pcfg_mem[p_ix] <= reg_wdata;
        if (mc_we) mcfg_mem[m_ix] <= reg_wdata;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_bad_psel_wr;
        ps_wr && ctrl_ff[`CTL_CHK_PID] && (w_sel >= PCNT);
    endsequence

    a_psel_reject: assert property (s_bad_psel_wr |=> $stable(pid_ff) &&
        esr_ff[$past(secure_space_bit)][`F_CODE] == `ERR_PARTITION_IDENTIFIER)
        else $error("bad partition write not rejected");

    a_use_code_one: assert property (pc_acc && pid_ff >= PCNT |=>
        esr_ff[$past(secure_space_bit)][`F_CODE] == `ERR_PARTITION_IDENTIFIER)
        else $error("partition range error not recorded");

    a_zero_read: assert property (pc_rd && pc_err && ctrl_ff[`CTL_ZERO_RD] |=>
        reg_rdata == `WORD_ZERO)
        else $error("erroneous read not zero");

    a_write_drop: assert property (pc_we |-> pid_ff < PCNT && pris_ff < RCNT)
        else $error("erroneous config write kept");

    a_ris_reject: assert property (ps_wr && !rej_pid && ctrl_ff[`CTL_CHK_RIS] &&
        w_ris >= RCNT |=> $stable(pris_ff) && esr_ff[$past(ns_ix)][`F_CODE] == `ERR_RIS)
        else $error("bad instance write not rejected");

    a_fid_code: assert property (fi_rd && pris_ff >= RCNT |=>
        esr_ff[$past(ns_ix)][`F_CODE] == `ERR_RIS &&
        esr_ff[$past(ns_ix)][`F_RIS] == $past(pris_ff))
        else $error("identification read error not recorded");

    a_mon_reject: assert property (ms_wr && ctrl_ff[`CTL_CHK_MON] && !new_mris_bad &&
        w_sel >= mon_lim_new |=> $stable(mon_ff) && esr_ff[$past(ns_ix)][`F_CODE] == `ERR_MONSEL)
        else $error("bad monitor select not rejected");

    a_mon_use: assert property (mc_acc && mris_ff < RCNT && mon_ff >= mon_lim_cur |=>
        esr_ff[$past(ns_ix)][`F_CODE] == `ERR_MONSEL)
        else $error("monitor range error not recorded");

    a_ovr_flag: assert property (err_vld && esr_ff[ns_ix][`F_CODE] != `ERR_NONE |=>
        esr_ff[$past(ns_ix)][`B_OVR])
        else $error("overwritten flag not set");

    a_copy_select: assert property (err_vld |=>
        esr_ff[!$past(ns_ix)] == $past(esr_ff[!ns_ix]))
        else $error("wrong error status copy written");
endmodule : selector_range_error_check

// >>> verification/tb.sv
// Purpose: Self-checking bench for the selector range checker register bank
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Check-at-write and zero-read options are driven through the control word
`timescale 1ns/10ps
`include "selchk_consts.svh"
module tb
    import selchk_pkg::*;
;
    // ----------------------------------------
    // Parameters and signals
    // ----------------------------------------
    localparam int          PARTS = 16;             // Implemented partitions
    localparam logic [31:0] FID   = 32'h0000_0C3C;  // Arbitrary identification value
    logic       sys_clk;           // Bench clock, 40 ns
    logic       reset_n;           // Synchronous reset, active low
    logic [7:0] reg_addr;          // Byte address
    word_t      reg_wdata;         // Write data
    logic       reg_wr;            // Write strobe
    logic       reg_rd;            // Read strobe
    logic       secure_space_bit;  // Error status copy select
    word_t      reg_rdata;         // Read data
    int         n_fail;            // Mismatches seen
    int         cmp_count;         // Comparisons made

    // ----------------------------------------
    // Design under test
    // ----------------------------------------
    selector_range_error_check #(
        .PART_COUNT (PARTS),
        .RIS_COUNT  (3),
        .MON_DEPTH  (8),
        .MON_LIMITS (64'h0008_0008_0004_0004),
        .FEATURE_ID (FID)
    ) selector_range_error_check_i (
        .sys_clk          (sys_clk),
        .reset_n          (reset_n),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .secure_space_bit (secure_space_bit),
        .reg_rdata        (reg_rdata)
    );

    // Free running clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Hang guard, far beyond the 151 cycles the run needs
    initial begin
        #(40 * 5000);
        n_fail = n_fail + 1;
        finish_test();
    end

    // ----------------------------------------
    // Bus tasks, each entered just after a rising edge
    // ----------------------------------------
    // Gap cycle after every strobe keeps a strobe from being assigned twice per step
    task automatic wr(input logic [7:0] a, input word_t d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    // Data is sampled once the taking edge has settled, the only cycle it stands
    task automatic rchk(input string name, input logic [7:0] a, input word_t exp);
        word_t got;
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        got = reg_rdata;
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
        @(posedge sys_clk);
    endtask : rchk

    // Error status word built from its fields
    function automatic word_t esr(input logic ovr, input logic [3:0] resource_instance_selector,
                                  input err_code_t code, input logic [15:0] sel);
        esr = {ovr, 3'h0, resource_instance_selector, 4'h0, code, sel};
    endfunction : esr

    // Selector word, instance in 27:24 and selector in 15:0
    function automatic word_t sw(input logic [3:0] resource_instance_selector, input logic [15:0] sel);
        sw = {4'h0, resource_instance_selector, 8'h00, sel};
    endfunction : sw

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset values, feature word and an unmapped place
    task automatic s_reset();
        rchk("psel", `OFF_PSEL, `WORD_ZERO);
        rchk("msel", `OFF_MSEL, `WORD_ZERO);
        rchk("ctrl", `OFF_CTRL, 32'h0000_000F);
        rchk("esr", `OFF_ESR, `WORD_ZERO);
        rchk("fid", `OFF_FID, FID);
        wr(8'h1C, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h1C, `WORD_ZERO);
    endtask : s_reset

    // Write-time rejects of partition and instance, back to back, second overwrites
    task automatic s_part_write();
        wr(`OFF_PSEL, sw(4'h1, 16'h0005));
        rchk("psel ok", `OFF_PSEL, sw(4'h1, 16'h0005));
        wr(`OFF_PSEL, sw(4'h1, 16'(PARTS)));
        rchk("psel kept", `OFF_PSEL, sw(4'h1, 16'h0005));
        rchk("esr pid", `OFF_ESR, esr(1'b0, 4'h1, `ERR_PARTITION_IDENTIFIER, 16'(PARTS)));
        wr(`OFF_PSEL, sw(4'h3, 16'h0002));
        rchk("psel kept2", `OFF_PSEL, sw(4'h1, 16'h0005));
        rchk("esr ris", `OFF_ESR, esr(1'b1, 4'h3, `ERR_RIS, 16'h0002));
        wr(`OFF_ESR, `WORD_ZERO);
        rchk("esr clr", `OFF_ESR, `WORD_ZERO);
    endtask : s_part_write

    // Monitor select bound follows the written instance; non-secure copy records it
    task automatic s_mon_write();
        secure_space_bit <= 1'b1;
        wr(`OFF_MSEL, sw(4'h0, 16'h0004));
        rchk("msel kept", `OFF_MSEL, `WORD_ZERO);
        rchk("esr ns", `OFF_ESR, esr(1'b0, 4'h0, `ERR_MONSEL, 16'h0004));
        secure_space_bit <= 1'b0;
        rchk("esr s", `OFF_ESR, `WORD_ZERO);
        wr(`OFF_MSEL, sw(4'h2, 16'h0004));
        rchk("msel ok", `OFF_MSEL, sw(4'h2, 16'h0004));
        secure_space_bit <= 1'b1;
        wr(`OFF_ESR, `WORD_ZERO);
        secure_space_bit <= 1'b0;
    endtask : s_mon_write

    // Stored bad partition: reads zero and flag, writes dropped
    task automatic s_use_part();
        wr(`OFF_CTRL, 32'h0000_0008);
        wr(`OFF_PSEL, sw(4'h1, 16'h0004));
        wr(`OFF_PCFG, 32'hA5A5_0001);
        wr(`OFF_PSEL, sw(4'h1, 16'h0014));
        rchk("psel bad", `OFF_PSEL, sw(4'h1, 16'h0014));
        rchk("pcfg zero", `OFF_PCFG, `WORD_ZERO);
        rchk("esr rd", `OFF_ESR, esr(1'b0, 4'h1, `ERR_PARTITION_IDENTIFIER, 16'h0014));
        wr(`OFF_ESR, `WORD_ZERO);
        wr(`OFF_PCFG, 32'h5A5A_0002);
        rchk("esr wr", `OFF_ESR, esr(1'b0, 4'h1, `ERR_PARTITION_IDENTIFIER, 16'h0014));
        wr(`OFF_ESR, `WORD_ZERO);
        wr(`OFF_PSEL, sw(4'h1, 16'h0004));
        rchk("pcfg kept", `OFF_PCFG, 32'hA5A5_0001);
    endtask : s_use_part

    // Stored undefined instance: feature and config accesses flag code 8
    // Instance 5 truncates onto instance 1, so a write that was kept would show
    task automatic s_use_ris();
        wr(`OFF_PSEL, sw(4'h5, 16'h0004));
        rchk("fid bad ris", `OFF_FID, FID);
        rchk("esr fid", `OFF_ESR, esr(1'b0, 4'h5, `ERR_RIS, 16'h0004));
        wr(`OFF_ESR, `WORD_ZERO);
        rchk("pcfg ris", `OFF_PCFG, `WORD_ZERO);
        rchk("esr cfg", `OFF_ESR, esr(1'b0, 4'h5, `ERR_RIS, 16'h0004));
        wr(`OFF_ESR, `WORD_ZERO);
        wr(`OFF_PCFG, 32'h1111_0003);
        rchk("esr cwr", `OFF_ESR, esr(1'b0, 4'h5, `ERR_RIS, 16'h0004));
        wr(`OFF_ESR, `WORD_ZERO);
        wr(`OFF_PSEL, sw(4'h1, 16'h0004));
        rchk("pcfg kept2", `OFF_PCFG, 32'hA5A5_0001);
    endtask : s_use_ris

    // Stored bad monitor select flags code 5 on a monitor config access
    // Selector 10 truncates onto selector 2, so a write that was kept would show
    task automatic s_use_mon();
        wr(`OFF_MSEL, sw(4'h0, 16'h0002));
        wr(`OFF_MCFG, 32'h3C3C_0004);
        rchk("mcfg ok", `OFF_MCFG, 32'h3C3C_0004);
        wr(`OFF_MSEL, sw(4'h0, 16'h000A));
        rchk("msel bad", `OFF_MSEL, sw(4'h0, 16'h000A));
        rchk("mcfg zero", `OFF_MCFG, `WORD_ZERO);
        rchk("esr mon", `OFF_ESR, esr(1'b0, 4'h0, `ERR_MONSEL, 16'h000A));
        wr(`OFF_ESR, `WORD_ZERO);
        wr(`OFF_MCFG, 32'h7777_0005);
        rchk("esr mwr", `OFF_ESR, esr(1'b0, 4'h0, `ERR_MONSEL, 16'h000A));
    endtask : s_use_mon

    // Zero-read off: erroneous reads give the truncated index's word; flag stays sticky
    task automatic s_trunc_read();
        wr(`OFF_CTRL, `WORD_ZERO);
        rchk("ctrl off", `OFF_CTRL, `WORD_ZERO);
        rchk("mcfg trunc", `OFF_MCFG, 32'h3C3C_0004);
        wr(`OFF_PSEL, sw(4'h1, 16'h0014));
        rchk("pcfg trunc", `OFF_PCFG, 32'hA5A5_0001);
        rchk("esr ovr", `OFF_ESR, esr(1'b1, 4'h1, `ERR_PARTITION_IDENTIFIER, 16'h0014));
    endtask : s_trunc_read

    // ----------------------------------------
    // Verdict
    // ----------------------------------------
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Main sequence: reset for 20 cycles, then the scenarios in turn
    initial begin
        n_fail = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = `WORD_ZERO;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        secure_space_bit = 1'b0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        s_reset();
        s_part_write();
        s_mon_write();
        s_use_part();
        s_use_ris();
        s_use_mon();
        s_trunc_read();
        finish_test();
    end
endmodule : tb
